// ==== shared/hlfb_consts.vh ====
// Functional notes
// - frame order: preamble, start, address, command, count, status, data, checksum
// - every frame opens with at least three 0xFF preamble bytes
// - module inserts the preamble; controller message is a channel byte and the designator, then the frame from the start character
// - long start codes: 0x82 master to slave, 0x86 reply, 0x81 burst
// - only long-format frames are accepted or generated
// - burst frames are not treated as valid traffic
// - long address is five bytes holding a 38-bit slave address
// - address holds a two-byte type code and a three-byte identifier
// - address MSB is the master bit; this primary master sends 1
// - command is one byte; 254 means an expansion command byte follows
// - byte count covers status and data, not the checksum
// - data field is 0 to 25 bytes
// - checksum is XOR of all bytes from start character onward
// - each byte carries its own parity bit (odd parity)
`ifndef HLFB_CONSTS_VH
`define HLFB_CONSTS_VH

// frame byte values
`define HLFB_PREAMBLE_BYTE 8'hFF
`define HLFB_START_M2S     8'h82
`define HLFB_START_S2M     8'h86
`define HLFB_START_BURST   8'h81
`define HLFB_EXPAND_CMD    8'hFE
`define HLFB_DESIGNATOR    8'h01
`define HLFB_MASTER_MASK   8'h80

// field lengths and limits
`define HLFB_PRE_TX_COUNT  4'h5
`define HLFB_PRE_MIN       4'h3
`define HLFB_PRE_MAX       4'hF
`define HLFB_ADDR_LAST     5'h04
`define HLFB_MAX_DATA      8'h19
`define HLFB_STATUS_LEN    8'h02
`define HLFB_MAX_REPLY_CNT 8'h1B

// reply error codes
`define HLFB_ERR_NONE      3'h0
`define HLFB_ERR_PARITY    3'h1
`define HLFB_ERR_START     3'h2
`define HLFB_ERR_COUNT     3'h3
`define HLFB_ERR_CHECKSUM  3'h4
`define HLFB_ERR_ECHO      3'h5

// request buffer
`define HLFB_FIFO_WIDTH    9
`define HLFB_FIFO_DEPTH    16
`define HLFB_FIFO_AW       4

`endif

// ==== rtl/hlfb_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
module hlfb_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk_in,
  input  wire             reset_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output reg              in_ready_out,
  output reg  [WIDTH-1:0] out_data_out,
  output reg              out_valid_out,
  input  wire             out_ready_in
);
  localparam [AW:0] FULL_COUNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  assign push = in_valid_in && in_ready_out;
  // refill the output register when it is empty or being consumed
  assign pop  = (count != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

  // word count of the storage array
  always @* begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // storage array, no reset needed
  always @(posedge ref_clk_in) begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  // pointers, count, registered ready and read data
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr        <= {AW{1'b0}};
      rd_ptr        <= {AW{1'b0}};
      count         <= {(AW+1){1'b0}};
      in_ready_out  <= 1'b0;
      out_data_out  <= {WIDTH{1'b0}};
      out_valid_out <= 1'b0;
    end else begin
      count        <= next_count;
      in_ready_out <= (next_count != FULL_COUNT);
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop) begin
        out_data_out  <= mem[rd_ptr];
        out_valid_out <= 1'b1;
        rd_ptr        <= rd_ptr + 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end
endmodule // hlfb_fifo
`default_nettype wire

// ==== rtl/hlfb_frame_builder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hlfb_consts.vh"
module hlfb_frame_builder (
  input  wire        ref_clk_in,
  input  wire        reset_in,
  // controller request stream
  input  wire [7:0]  ctl_data_in,
  input  wire        ctl_last_in,
  input  wire        ctl_valid_in,
  output wire        ctl_ready_out,
  // request status
  output reg  [7:0]  req_channel_out,
  output reg         req_done_out,
  output reg         req_error_out,
  // byte stream to the modem
  output reg  [7:0]  tx_data_out,
  output reg         tx_parity_out,
  output reg         tx_valid_out,
  input  wire        tx_ready_in,
  output reg         tx_abort_out,
  // byte stream from the modem
  input  wire [7:0]  rx_data_in,
  input  wire        rx_parity_in,
  input  wire        rx_valid_in,
  // reply results
  output reg  [39:0] rx_addr_out,
  output reg  [7:0]  rx_cmd_out,
  output reg  [7:0]  rx_status1_out,
  output reg  [7:0]  rx_status2_out,
  output reg  [7:0]  rx_data_out,
  output reg         rx_data_valid_out,
  output reg         rx_done_out,
  output reg         rx_error_out,
  output reg  [2:0]  rx_error_code_out
);
  localparam [3:0] T_IDLE  = 4'h0;
  localparam [3:0] T_DESIG = 4'h1;
  localparam [3:0] T_START = 4'h2;
  localparam [3:0] T_PRE   = 4'h3;
  localparam [3:0] T_SOF   = 4'h4;
  localparam [3:0] T_ADDR  = 4'h5;
  localparam [3:0] T_CMD   = 4'h6;
  localparam [3:0] T_CNT   = 4'h7;
  localparam [3:0] T_DATA  = 4'h8;
  localparam [3:0] T_CSUM  = 4'h9;
  localparam [3:0] T_DROP  = 4'hA;

  localparam [3:0] R_HUNT  = 4'h0;
  localparam [3:0] R_ADDR  = 4'h1;
  localparam [3:0] R_CMD   = 4'h2;
  localparam [3:0] R_CNT   = 4'h3;
  localparam [3:0] R_STAT1 = 4'h4;
  localparam [3:0] R_STAT2 = 4'h5;
  localparam [3:0] R_DATA  = 4'h6;
  localparam [3:0] R_CSUM  = 4'h7;

  // odd parity bit for one byte
  function odd_parity;
    input [7:0] b;
    begin
      odd_parity = ~(^b);
    end
  endfunction

  wire [8:0] fifo_data;
  wire       fifo_valid;
  reg        fifo_take;
  wire [7:0] f_data;
  wire       f_last;
  wire       can_out;
  wire [7:0] tx_byte;

  reg [3:0]  tx_state;
  reg [3:0]  pre_cnt;
  reg [7:0]  start_hold;
  reg [7:0]  tx_csum;
  reg [4:0]  tx_idx;
  reg [7:0]  tx_left;
  reg [7:0]  tx_cmd;

  reg [3:0]  rx_state;
  reg [3:0]  rx_pre;
  reg [7:0]  rx_csum;
  reg [4:0]  rx_idx;
  reg [7:0]  rx_left;
  reg        echo_bad;

  // request buffer between controller and frame sender
  hlfb_fifo #(
    .WIDTH (`HLFB_FIFO_WIDTH),
    .DEPTH (`HLFB_FIFO_DEPTH),
    .AW    (`HLFB_FIFO_AW)
  ) u_req_fifo (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .in_data_in    ({ctl_last_in, ctl_data_in}),
    .in_valid_in   (ctl_valid_in),
    .in_ready_out  (ctl_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_take)
  );

  assign f_data  = fifo_data[7:0];
  assign f_last  = fifo_data[8];
  assign can_out = !tx_valid_out || tx_ready_in;
  // force the primary master bit into the first address byte
  assign tx_byte = (tx_state == T_ADDR && tx_idx == 5'h00) ?
                   (f_data | `HLFB_MASTER_MASK) : f_data;

  // pull from the buffer; sending stages also wait for the modem
  always @* begin
    fifo_take = 1'b0;
    case (tx_state)
      T_IDLE, T_DESIG, T_START, T_DROP: fifo_take = fifo_valid;
      T_ADDR, T_CMD, T_CNT, T_DATA, T_CSUM: fifo_take = fifo_valid && can_out;
      default: fifo_take = 1'b0;
    endcase
  end

  // request parser and frame sender
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_state        <= T_IDLE;
      pre_cnt         <= 4'h0;
      start_hold      <= 8'h00;
      tx_csum         <= 8'h00;
      tx_idx          <= 5'h00;
      tx_left         <= 8'h00;
      tx_cmd          <= 8'h00;
      req_channel_out <= 8'h00;
      req_done_out    <= 1'b0;
      req_error_out   <= 1'b0;
      tx_data_out     <= 8'h00;
      tx_parity_out   <= 1'b0;
      tx_valid_out    <= 1'b0;
      tx_abort_out    <= 1'b0;
    end else begin
      req_done_out  <= 1'b0;
      req_error_out <= 1'b0;
      tx_abort_out  <= 1'b0;
      if (tx_valid_out && tx_ready_in)
        tx_valid_out <= 1'b0;
      case (tx_state)
        T_IDLE: begin
          if (fifo_take) begin
            req_channel_out <= f_data;
            if (f_last)
              req_error_out <= 1'b1;
            else
              tx_state <= T_DESIG;
          end
        end
        T_DESIG: begin
          if (fifo_take) begin
            if (f_data != `HLFB_DESIGNATOR || f_last) begin
              req_error_out <= 1'b1;
              tx_state      <= f_last ? T_IDLE : T_DROP;
            end else begin
              tx_state <= T_START;
            end
          end
        end
        T_START: begin
          if (fifo_take) begin
            // only long master-to-slave requests leave this module
            if (f_data != `HLFB_START_M2S || f_last) begin
              req_error_out <= 1'b1;
              tx_state      <= f_last ? T_IDLE : T_DROP;
            end else begin
              start_hold <= f_data;
              pre_cnt    <= 4'h0;
              tx_state   <= T_PRE;
            end
          end
        end
        T_PRE: begin
          if (can_out) begin
            tx_data_out   <= `HLFB_PREAMBLE_BYTE;
            tx_parity_out <= odd_parity(`HLFB_PREAMBLE_BYTE);
            tx_valid_out  <= 1'b1;
            pre_cnt       <= pre_cnt + 1'b1;
            if (pre_cnt == `HLFB_PRE_TX_COUNT - 1'b1)
              tx_state <= T_SOF;
          end
        end
        T_SOF: begin
          if (can_out) begin
            tx_data_out   <= start_hold;
            tx_parity_out <= odd_parity(start_hold);
            tx_valid_out  <= 1'b1;
            tx_csum       <= start_hold;
            tx_idx        <= 5'h00;
            tx_state      <= T_ADDR;
          end
        end
        T_ADDR, T_CMD, T_CNT, T_DATA: begin
          if (fifo_take) begin
            tx_data_out   <= tx_byte;
            tx_parity_out <= odd_parity(tx_byte);
            tx_valid_out  <= 1'b1;
            tx_csum       <= tx_csum ^ tx_byte;
            if (f_last) begin
              // request ended before its checksum byte
              tx_abort_out  <= 1'b1;
              req_error_out <= 1'b1;
              tx_state      <= T_IDLE;
            end else if (tx_state == T_ADDR) begin
              tx_idx <= tx_idx + 1'b1;
              if (tx_idx == `HLFB_ADDR_LAST)
                tx_state <= T_CMD;
            end else if (tx_state == T_CMD) begin
              tx_cmd   <= f_data;
              tx_state <= T_CNT;
            end else if (tx_state == T_CNT) begin
              tx_left <= f_data;
              if (f_data > `HLFB_MAX_DATA) begin
                tx_abort_out  <= 1'b1;
                req_error_out <= 1'b1;
                tx_state      <= T_DROP;
              end else begin
                tx_state <= (f_data == 8'h00) ? T_CSUM : T_DATA;
              end
            end else begin
              // an expansion command byte travels as the first data byte
              tx_left <= tx_left - 1'b1;
              if (tx_left == 8'h01)
                tx_state <= T_CSUM;
            end
          end
        end
        T_CSUM: begin
          if (fifo_take) begin
            // send the recomputed sum, since the master bit may have changed
            tx_data_out   <= tx_csum;
            tx_parity_out <= odd_parity(tx_csum);
            tx_valid_out  <= 1'b1;
            req_done_out  <= f_last;
            req_error_out <= !f_last;
            tx_state      <= f_last ? T_IDLE : T_DROP;
          end
        end
        T_DROP: begin
          if (fifo_take && f_last)
            tx_state <= T_IDLE;
        end
        default: tx_state <= T_IDLE;
      endcase
    end
  end

  // reply receiver and checker
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_state          <= R_HUNT;
      rx_pre            <= 4'h0;
      rx_csum           <= 8'h00;
      rx_idx            <= 5'h00;
      rx_left           <= 8'h00;
      echo_bad          <= 1'b0;
      rx_addr_out       <= 40'h0000000000;
      rx_cmd_out        <= 8'h00;
      rx_status1_out    <= 8'h00;
      rx_status2_out    <= 8'h00;
      rx_data_out       <= 8'h00;
      rx_data_valid_out <= 1'b0;
      rx_done_out       <= 1'b0;
      rx_error_out      <= 1'b0;
      rx_error_code_out <= `HLFB_ERR_NONE;
    end else begin
      rx_data_valid_out <= 1'b0;
      rx_done_out       <= 1'b0;
      rx_error_out      <= 1'b0;
      if (rx_valid_in) begin
        if ((rx_state != R_HUNT || (rx_data_in != `HLFB_PREAMBLE_BYTE && rx_pre >= `HLFB_PRE_MIN))
            && rx_parity_in != odd_parity(rx_data_in)) begin
          rx_error_out      <= 1'b1;
          rx_error_code_out <= `HLFB_ERR_PARITY;
          rx_pre            <= 4'h0;
          rx_state          <= R_HUNT;
        end else begin
          rx_csum <= rx_csum ^ rx_data_in;
          case (rx_state)
            R_HUNT: begin
              if (rx_data_in == `HLFB_PREAMBLE_BYTE) begin
                if (rx_pre != `HLFB_PRE_MAX)
                  rx_pre <= rx_pre + 1'b1;
              end else begin
                rx_pre <= 4'h0;
                if (rx_pre >= `HLFB_PRE_MIN) begin
                  rx_csum <= rx_data_in;
                  rx_idx  <= 5'h00;
                  if (rx_data_in == `HLFB_START_S2M) begin
                    rx_state <= R_ADDR;
                  end else if (rx_data_in != `HLFB_START_M2S) begin
                    // short, burst or unknown start: not our traffic
                    rx_error_out      <= 1'b1;
                    rx_error_code_out <= `HLFB_ERR_START;
                  end
                end
              end
            end
            R_ADDR: begin
              rx_addr_out <= {rx_addr_out[31:0], rx_data_in};
              rx_idx      <= rx_idx + 1'b1;
              if (rx_idx == `HLFB_ADDR_LAST)
                rx_state <= R_CMD;
            end
            R_CMD: begin
              rx_cmd_out <= rx_data_in;
              echo_bad   <= (rx_data_in != tx_cmd);
              rx_state   <= R_CNT;
            end
            R_CNT: begin
              if (rx_data_in < `HLFB_STATUS_LEN || rx_data_in > `HLFB_MAX_REPLY_CNT) begin
                rx_error_out      <= 1'b1;
                rx_error_code_out <= `HLFB_ERR_COUNT;
                rx_state          <= R_HUNT;
              end else begin
                rx_left  <= rx_data_in - `HLFB_STATUS_LEN;
                rx_state <= R_STAT1;
              end
            end
            R_STAT1: begin
              rx_status1_out <= rx_data_in;
              rx_state       <= R_STAT2;
            end
            R_STAT2: begin
              rx_status2_out <= rx_data_in;
              rx_state       <= (rx_left == 8'h00) ? R_CSUM : R_DATA;
            end
            R_DATA: begin
              rx_data_out       <= rx_data_in;
              rx_data_valid_out <= 1'b1;
              rx_left           <= rx_left - 1'b1;
              if (rx_left == 8'h01)
                rx_state <= R_CSUM;
            end
            R_CSUM: begin
              rx_state <= R_HUNT;
              if (rx_data_in != rx_csum) begin
                rx_error_out      <= 1'b1;
                rx_error_code_out <= `HLFB_ERR_CHECKSUM;
              end else if (echo_bad) begin
                rx_error_out      <= 1'b1;
                rx_error_code_out <= `HLFB_ERR_ECHO;
              end else begin
                rx_done_out       <= 1'b1;
                rx_error_code_out <= `HLFB_ERR_NONE;
              end
            end
            default: rx_state <= R_HUNT;
          endcase
        end
      end
    end
  end
endmodule // hlfb_frame_builder
`default_nettype wire

// ==== tb/hlfb_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module hlfb_assertions (
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_parity_out,
  input wire logic       tx_valid_out,
  input wire logic       tx_ready_in,
  input wire logic       tx_abort_out,
  input wire logic       rx_valid_in,
  input wire logic       rx_done_out,
  input wire logic       rx_error_out
);
  logic [5:0] pos;
  logic [7:0] cnt;
  logic [7:0] acc;
  wire        take = tx_valid_out && tx_ready_in;
  wire        at_end = (pos > 6'd12) && (pos == 6'd13 + cnt[5:0]);

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // byte position in the outgoing frame and the running checksum from the start code
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pos <= 6'h00;
      cnt <= 8'h00;
      acc <= 8'h00;
    end else if (tx_abort_out) begin
      pos <= 6'h00;
    end else if (take) begin
      pos <= at_end ? 6'h00 : pos + 6'h01;
      acc <= (pos == 6'd5) ? tx_data_out : acc ^ tx_data_out;
      if (pos == 6'd12) cnt <= tx_data_out;
    end
  end

  chk_pre_ff: assert property (take && pos < 6'd5 |-> tx_data_out == 8'hFF)
    else $error("preamble byte is not FF");
  chk_start_code: assert property (take && pos == 6'd5 |-> tx_data_out == 8'h82)
    else $error("request start code wrong");
  chk_master_bit: assert property (take && pos == 6'd6 |-> tx_data_out[7])
    else $error("master address bit not set");
  chk_frame_xor: assert property (take && at_end |-> tx_data_out == acc)
    else $error("request checksum wrong");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
                                tx_abort_out || (tx_valid_out && $stable(tx_data_out)))
    else $error("offered byte changed before taken");
  chk_parity_odd: assert property (tx_valid_out |-> ^{tx_data_out, tx_parity_out})
    else $error("byte parity not odd");
  chk_rx_result_cause: assert property (rx_done_out || rx_error_out |-> $past(rx_valid_in))
    else $error("reply result without a received byte");
  chk_rx_done_excl: assert property (rx_done_out |-> !rx_error_out)
    else $error("reply both good and in error");
endmodule // hlfb_assertions

bind hlfb_frame_builder hlfb_assertions u_chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .tx_data_out(tx_data_out),
  .tx_parity_out(tx_parity_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .tx_abort_out(tx_abort_out), .rx_valid_in(rx_valid_in), .rx_done_out(rx_done_out),
  .rx_error_out(rx_error_out)
);
`default_nettype wire

// ==== tb/hlfb_modem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hlfb_modem_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_parity_out,
  output logic            rx_valid_out
);
  localparam logic [39:0] SLAVE_ADDR = 40'hBE020C7737;
  logic [7:0] tx_log [0:255];
  int         tx_n = 0;
  int         stall = 0;
  int         cyc = 0;

  initial begin
    tx_ready_out = 1'b0;
    rx_data_out = 8'h00;
    rx_parity_out = 1'b1;
    rx_valid_out = 1'b0;
  end

  // log every byte taken; stall 0 prompt, 1 one cycle in three, 2 stopped
  always @(posedge ref_clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      tx_log[tx_n[7:0]] <= tx_data_in;
      tx_n <= tx_n + 1;
    end
    cyc <= cyc + 1;
  end
  always @(posedge ref_clk_in) begin
    #1;
    tx_ready_out = (stall == 0) || (stall == 1 && cyc % 3 == 0);
  end

  // one reply frame, one strobe every other cycle, line inverted between bytes
  task automatic send_reply(input logic [7:0] start, input logic [7:0] cmd,
                            input logic [7:0] cnt, input logic bad_cs, input logic bad_par);
    logic [7:0] f [0:47];
    logic [7:0] cs;
    int         n;
    int         i;
    n = 0;
    for (i = 0; i < 3; i++) f[n++] = 8'hFF;
    f[n++] = start;
    for (i = 0; i < 5; i++) f[n++] = SLAVE_ADDR[39 - 8 * i -: 8];
    f[n++] = cmd;
    f[n++] = cnt;
    for (i = 0; i < cnt; i++)
      f[n++] = (i == 0) ? 8'h20 : (i == 1) ? 8'h40 : 8'h20 + i[7:0];
    cs = 8'h00;
    for (i = 3; i < n; i++) cs = cs ^ f[i];
    f[n++] = cs ^ {7'h00, bad_cs};
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      #1;
      rx_data_out = f[i];
      rx_parity_out = ~^f[i] ^ (bad_par && i == 5);
      rx_valid_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      rx_valid_out = 1'b0;
      rx_data_out = ~f[i];
    end
  endtask
endmodule // hlfb_modem_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  ctl_data_in = 8'h00;
  logic        ctl_last_in = 1'b0;
  logic        ctl_valid_in = 1'b0;
  logic        ctl_ready_out, req_done_out, req_error_out, tx_parity_out, tx_valid_out;
  logic        tx_ready_in, tx_abort_out, rx_parity_in, rx_valid_in, rx_data_valid_out;
  logic        rx_done_out, rx_error_out;
  logic [7:0]  req_channel_out, tx_data_out, rx_data_in, rx_cmd_out, rx_status1_out;
  logic [7:0]  rx_status2_out, rx_data_out;
  logic [39:0] rx_addr_out;
  logic [2:0]  rx_error_code_out;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_done = 0, n_rej = 0, n_ok = 0, n_bad = 0, n_dat = 0;
  logic        full_seen = 1'b0;

  hlfb_frame_builder u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .ctl_data_in(ctl_data_in), .ctl_last_in(ctl_last_in), .ctl_valid_in(ctl_valid_in),
    .ctl_ready_out(ctl_ready_out), .req_channel_out(req_channel_out),
    .req_done_out(req_done_out), .req_error_out(req_error_out), .tx_data_out(tx_data_out),
    .tx_parity_out(tx_parity_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .tx_abort_out(tx_abort_out), .rx_data_in(rx_data_in), .rx_parity_in(rx_parity_in),
    .rx_valid_in(rx_valid_in), .rx_addr_out(rx_addr_out), .rx_cmd_out(rx_cmd_out),
    .rx_status1_out(rx_status1_out), .rx_status2_out(rx_status2_out),
    .rx_data_out(rx_data_out), .rx_data_valid_out(rx_data_valid_out),
    .rx_done_out(rx_done_out), .rx_error_out(rx_error_out),
    .rx_error_code_out(rx_error_code_out));
  hlfb_modem_model u_modem (.ref_clk_in(ref_clk_in), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in), .rx_data_out(rx_data_in),
    .rx_parity_out(rx_parity_in), .rx_valid_out(rx_valid_in));

  always #10 ref_clk_in = ~ref_clk_in;

  // count result pulses and note a refused request byte
  always @(posedge ref_clk_in) begin
    if (req_done_out === 1'b1) n_done++;
    if (req_error_out === 1'b1) n_rej++;
    if (rx_done_out === 1'b1) n_ok++;
    if (rx_error_out === 1'b1) n_bad++;
    if (rx_data_valid_out === 1'b1) n_dat++;
    if (ctl_valid_in && ctl_ready_out === 1'b0 && !reset_in) full_seen = 1'b1;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wait_cnt(ref int c, input int tgt);
    for (int k = 0; k < 3000 && c < tgt; k++) @(posedge ref_clk_in);
  endtask

  // hold a byte until an edge where ready stood high
  task automatic put_byte(input logic [7:0] b, input logic last);
    logic rdy;
    ctl_data_in = b;
    ctl_last_in = last;
    for (int k = 0; k < 2000; k++) begin
      rdy = ctl_ready_out;
      @(posedge ref_clk_in);
      #1;
      if (rdy === 1'b1) break;
    end
  endtask

  task automatic send_req(input logic [7:0] des, input logic [7:0] start,
                          input logic [7:0] cnt, input int nd);
    logic [7:0] q [$];
    @(posedge ref_clk_in);
    #1;
    q = '{8'h02, des, start, 8'h3E, 8'h02, 8'h0C, 8'h77, 8'h37, 8'h23, cnt};
    for (int i = 0; i < nd; i++) q.push_back(8'h40 + 8'(i));
    q.push_back(8'hFF);
    ctl_valid_in = 1'b1;
    foreach (q[j]) put_byte(q[j], j == q.size() - 1);
    ctl_valid_in = 1'b0;
    ctl_last_in = 1'b0;
  endtask

  // longest request while the modem stalls: buffer refuses, then drains
  task automatic s_tx_frame();
    logic [7:0] e [$];
    logic [7:0] cs;
    int         base;
    base = u_modem.tx_n;
    u_modem.stall = 2;
    fork
      send_req(8'h01, 8'h82, 8'h19, 25);
      begin repeat (60) @(posedge ref_clk_in); u_modem.stall = 1; end
    join
    wait_cnt(n_done, 1);
    repeat (10) @(posedge ref_clk_in);
    e = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h82, 8'hBE, 8'h02, 8'h0C, 8'h77, 8'h37,
          8'h23, 8'h19};
    for (int i = 0; i < 25; i++) e.push_back(8'h40 + 8'(i));
    cs = 8'h00;
    for (int i = 5; i < e.size(); i++) cs = cs ^ e[i];
    e.push_back(cs);
    chk(40'(u_modem.tx_n - base), 40'(e.size()));
    foreach (e[j]) chk(u_modem.tx_log[8'(base + j)], e[j]);
    chk(full_seen, 1'b1);
    chk(req_channel_out, 8'h02);
    u_modem.stall = 0;
  endtask

  // bad designator, short and burst start codes, count above 25
  task automatic s_req_errors();
    logic [7:0] des [4] = '{8'h02, 8'h01, 8'h01, 8'h01};
    logic [7:0] st [4] = '{8'h82, 8'h02, 8'h81, 8'h82};
    logic [7:0] cn [4] = '{8'h09, 8'h09, 8'h09, 8'h1A};
    int         r0;
    for (int i = 0; i < 4; i++) begin
      r0 = n_rej;
      send_req(des[i], st[i], cn[i], 2);
      wait_cnt(n_rej, r0 + 1);
      chk(40'(n_rej), 40'(r0 + 1));
      chk(40'(n_done), 40'd1);
      repeat (20) @(posedge ref_clk_in);
    end
  endtask

  task automatic s_reply_good();
    int d0;
    d0 = n_dat;
    u_modem.send_reply(8'h86, 8'h23, 8'h0B, 1'b0, 1'b0);
    wait_cnt(n_ok, 1);
    chk(40'(n_ok), 40'd1);
    chk(rx_addr_out, 40'hBE020C7737);
    chk(rx_cmd_out, 8'h23);
    chk({rx_status1_out, rx_status2_out}, 16'h2040);
    chk(40'(n_dat - d0), 40'd9);
    chk(rx_data_out, 8'h2A);
    chk(rx_error_code_out, 3'h0);
  endtask

  // checksum, burst, short, echo, parity and count faults in replies
  task automatic s_reply_errs();
    logic [7:0] st [6] = '{8'h86, 8'h81, 8'h06, 8'h86, 8'h86, 8'h86};
    logic [7:0] cm [6] = '{8'h23, 8'h23, 8'h23, 8'h24, 8'h23, 8'h23};
    logic [7:0] cn [6] = '{8'h0B, 8'h0B, 8'h0B, 8'h0B, 8'h0B, 8'h1C};
    logic [2:0] cd [6] = '{3'h4, 3'h2, 3'h2, 3'h5, 3'h1, 3'h3};
    int         b0;
    for (int i = 0; i < 6; i++) begin
      b0 = n_bad;
      u_modem.send_reply(st[i], cm[i], cn[i], i == 0, i == 4);
      wait_cnt(n_bad, b0 + 1);
      chk(rx_error_code_out, cd[i]);
      chk(40'(n_ok), 40'd1);
      repeat (10) @(posedge ref_clk_in);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    #1;
    reset_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    s_tx_frame();
    s_req_errors();
    s_reply_good();
    s_reply_errs();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
